// File: rtl/tic_defs.svh
// Offsets, field positions, reset values and timing counts of the time interval counter
//
// Contract
// [R1] Timebase select 00/01/10/11 advances interval counter per 1/128 s, second, minute, hour.
// [R2] With single_shot set, a timeout clears interval_enable.
// [R3] With single_shot clear, the interval counter reloads at each timeout and continues.
// [R4] interval_flag is set when the interval counter equals interval_target.
// [R5] Software clears interval_flag; hardware never clears it.
// [R6] interval_enable runs the counter; clearing it stops and zeroes the counter.
// [R7] timeclock_enable gates the time clock; clearing it clears all time registers.
// [R8] Time-of-day registers accept writes while timeclock_enable is low.
// [R9] Software loads interval_target; match raises interrupt only when interrupt enabled.
// [R10] Fraction register counts 0..127 per 1/128 s; wrap increments seconds.
// [R11] Seconds count 0..59; wrap increments minutes.
// [R12] Minutes count 0..59; wrap increments hours.
// [R13] Hours count 0..23, then wrap to zero with no carry.
// [R14] Software should write one to reserved control bit 6; bit 7 reserved.
// [R15] Interval counter advances on each carry into the selected time register.
// [R16] Time chain runs from the crystal timebase and keeps counting in power-down.
// [R17] Enabled set interval_flag wakes the device and vectors to the interval interrupt.
// [R18] Auto-reload returns the counter to zero on the matching tick.
`ifndef TIC_DEFS_SVH
`define TIC_DEFS_SVH

`define TIC_ADDR_CTRL    8'ha1
`define TIC_ADDR_FRAC    8'ha2
`define TIC_ADDR_SECONDS 8'ha3
`define TIC_ADDR_MIN     8'ha4
`define TIC_ADDR_HOUR    8'ha5
`define TIC_ADDR_TARGET  8'ha6

`define TIC_BIT_CLK_EN   0
`define TIC_BIT_IVAL_EN  1
`define TIC_BIT_FLAG     2
`define TIC_BIT_ONE_SHOT 3
`define TIC_BIT_RES7     7

`define TIC_CTRL_RESET   8'h00
`define TIC_TIME_RESET   8'h00
`define TIC_TARGET_RESET 8'h00

`define TIC_FRAC_MAX     8'h7f
`define TIC_SECONDS_MAX  8'h3b
`define TIC_MIN_MAX      8'h3b
`define TIC_HOUR_MAX     8'h17

// Crystal-derived 1/128 s timebase counted in core clock cycles
`define TIC_CLK_HZ       250000000
`define TIC_FRAC_HZ      128

`endif

// File: rtl/tic_pkg.sv
// Types shared by the time interval counter
package tic_pkg;

  typedef enum logic [1:0] {
    TIC_TB_FRAC    = 2'b00,
    TIC_TB_SECONDS = 2'b01,
    TIC_TB_MIN     = 2'b10,
    TIC_TB_HOUR    = 2'b11
  } tic_tbase_type;

  typedef struct packed {
    logic          res7;
    logic          res6;
    tic_tbase_type tsel;
    logic          single_shot;
    logic          interval_flag;
    logic          interval_enable;
    logic          timeclock_enable;
  } tic_ctrl_type;

endpackage

// File: rtl/tic_top.sv
// Time interval counter: time-of-day chain, interval counter and control registers
`timescale 1ns/10ps
`include "tic_defs.svh"

module tic_top #(
  parameter int unsigned TICK_DIV = `TIC_CLK_HZ / `TIC_FRAC_HZ
) (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       reset_n_in,
  // Register port
  input  wire logic [7:0] sfr_addr_in,
  input  wire logic       sfr_wr_in,
  input  wire logic [7:0] sfr_wdata_in,
  output logic      [7:0] sfr_rdata_out,
  // Interrupt
  input  wire logic       irq_enable_in,
  output logic            irq_out
);

  localparam logic [7:0] LIMIT [4] = '{`TIC_FRAC_MAX, `TIC_SECONDS_MAX, `TIC_MIN_MAX, `TIC_HOUR_MAX};

  function automatic logic at_limit(input logic [7:0] v, input logic [7:0] lim);
    return v == lim;
  endfunction

  // Register write decode, shared by every writable register
  function automatic logic wr_hit(input logic wr, input logic [7:0] addr, input logic [7:0] reg_addr);
    return wr && (addr == reg_addr);
  endfunction

  // Reset release synchroniser
  logic [1:0] rst_sync_r;
  logic       rst_n;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_r[1];

  // State
  tic_pkg::tic_ctrl_type ctrl_r;
  tic_pkg::tic_ctrl_type ctrl_nxt;
  logic [31:0]           div_r;
  logic [31:0]           div_nxt;
  logic [7:0]            time_r [4];
  logic [7:0]            time_nxt [4];
  logic [7:0]            ival_r;
  logic [7:0]            ival_nxt;
  logic [7:0]            target_r;
  logic [7:0]            target_nxt;
  logic [7:0]            rdata_nxt;
  logic                  irq_nxt;

  logic       ctl_wr;
  logic       clk_en_fall;
  logic       ival_en_clr;
  logic       tick128;
  logic       tick_sel;
  logic       match;
  logic [7:0] ival_inc;
  logic [3:0] carry;
  logic [3:0] roll;

  assign ctl_wr      = wr_hit(sfr_wr_in, sfr_addr_in, `TIC_ADDR_CTRL);
  assign clk_en_fall = ctl_wr && ctrl_r.timeclock_enable && !sfr_wdata_in[`TIC_BIT_CLK_EN];
  // Zeroing on the clearing edge keeps a stopped counter at zero even with the time clock off
  assign ival_en_clr = ctl_wr && !sfr_wdata_in[`TIC_BIT_IVAL_EN];

  // Divider stands in for the crystal; it depends on nothing but timeclock_enable,
  // so core power-down leaves it counting
  always_comb begin
    div_nxt = div_r;
    if (!ctrl_r.timeclock_enable) begin
      div_nxt = 32'h0000_0000;
    end else if (tick128) begin
      div_nxt = 32'h0000_0000; // [R16]
    end else begin
      div_nxt = div_r + 32'h0000_0001;
    end
  end

  assign tick128 = ctrl_r.timeclock_enable && (div_r == TICK_DIV - 32'd1); // [R7]

  // Carry chain through fraction, seconds, minutes and hours
  assign carry[0] = tick128;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_chain
      assign roll[gi] = carry[gi] && at_limit(time_r[gi], LIMIT[gi]);
      if (gi < 3) begin : g_carry
        assign carry[gi+1] = roll[gi]; // [R10] [R11] [R12]
      end
    end
  endgenerate

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      time_nxt[i] = time_r[i];
      if (clk_en_fall) begin
        time_nxt[i] = `TIC_TIME_RESET; // [R7]
      end else if (!ctrl_r.timeclock_enable && wr_hit(sfr_wr_in, sfr_addr_in, 8'(`TIC_ADDR_FRAC + i))) begin
        time_nxt[i] = sfr_wdata_in; // [R8]
      end else if (roll[i]) begin
        time_nxt[i] = 8'h00; // [R13]
      end else if (carry[i]) begin
        time_nxt[i] = time_r[i] + 8'h01;
      end
    end
  end

  // Timebase selection for the interval counter
  always_comb begin
    unique case (ctrl_r.tsel)
      tic_pkg::TIC_TB_FRAC:    tick_sel = tick128; // [R1]
      tic_pkg::TIC_TB_SECONDS: tick_sel = roll[0]; // [R15]
      tic_pkg::TIC_TB_MIN:     tick_sel = roll[1];
      tic_pkg::TIC_TB_HOUR:    tick_sel = roll[2];
    endcase
  end

  assign ival_inc = ival_r + 8'h01;
  assign match    = ctrl_r.interval_enable && tick_sel && (ival_inc == target_r); // [R4]

  // Control, interval counter and target
  always_comb begin
    ctrl_nxt   = ctrl_r;
    ival_nxt   = ival_r;
    target_nxt = target_r;
    if (match && ctrl_r.single_shot) begin
      ctrl_nxt.interval_enable = 1'b0; // [R2]
    end
    if (ctl_wr) begin
      // Bit 6 is kept as written; bit 7 always reads zero
      ctrl_nxt      = tic_pkg::tic_ctrl_type'(sfr_wdata_in); // [R14]
      ctrl_nxt.res7 = 1'b0;
    end
    // A match in the cycle of a clearing write still leaves the flag set
    if (match) begin
      ctrl_nxt.interval_flag = 1'b1; // [R4] [R5]
    end
    if (!ctrl_r.interval_enable || clk_en_fall || ival_en_clr) begin
      ival_nxt = 8'h00; // [R6]
    end else if (tick_sel) begin
      ival_nxt = match ? 8'h00 : ival_inc; // [R3] [R18]
    end
    if (wr_hit(sfr_wr_in, sfr_addr_in, `TIC_ADDR_TARGET)) begin
      target_nxt = sfr_wdata_in; // [R9]
    end
  end

  // Read data and interrupt request
  always_comb begin
    unique case (sfr_addr_in)
      `TIC_ADDR_CTRL:    rdata_nxt = ctrl_r;
      `TIC_ADDR_FRAC:    rdata_nxt = time_r[0];
      `TIC_ADDR_SECONDS: rdata_nxt = time_r[1];
      `TIC_ADDR_MIN:     rdata_nxt = time_r[2];
      `TIC_ADDR_HOUR:    rdata_nxt = time_r[3];
      `TIC_ADDR_TARGET:  rdata_nxt = target_r;
      default:           rdata_nxt = 8'h00;
    endcase
  end

  // Request level doubles as the power-down wake; vectoring is the core's job
  assign irq_nxt = ctrl_r.interval_flag && irq_enable_in; // [R9] [R17]

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r        <= tic_pkg::tic_ctrl_type'(`TIC_CTRL_RESET);
      div_r         <= 32'h0000_0000;
      for (int i = 0; i < 4; i++) begin
        time_r[i] <= `TIC_TIME_RESET;
      end
      ival_r        <= 8'h00;
      target_r      <= `TIC_TARGET_RESET;
      sfr_rdata_out <= 8'h00;
      irq_out       <= 1'b0;
    end else begin
      ctrl_r        <= ctrl_nxt;
      div_r         <= div_nxt;
      for (int i = 0; i < 4; i++) begin
        time_r[i] <= time_nxt[i];
      end
      ival_r        <= ival_nxt;
      target_r      <= target_nxt;
      sfr_rdata_out <= rdata_nxt;
      irq_out       <= irq_nxt;
    end
  end

  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n);

  a_timebase_seconds: assert property ( // [R1]
    (ctrl_r.tsel == tic_pkg::TIC_TB_SECONDS && tick128 && time_r[0] != `TIC_FRAC_MAX) |-> !tick_sel
  ) else $error("seconds timebase advanced without fraction wrap");

  a_rollover_clock: assert property ( // [R15]
    (ctrl_r.tsel == tic_pkg::TIC_TB_MIN && ctrl_r.interval_enable && roll[1] && !match && !ctl_wr)
    |=> ival_r == 8'($past(ival_r) + 8'h01)
  ) else $error("interval counter missed minute rollover");

  a_single_stop: assert property ( // [R2]
    (match && ctrl_r.single_shot && !ctl_wr) |=> !ctrl_r.interval_enable && ival_r == 8'h00
  ) else $error("single shot did not stop");

  a_auto_reload: assert property ( // [R3]
    (match && !ctrl_r.single_shot && !ctl_wr) |=> ctrl_r.interval_enable && ival_r == 8'h00 // [R18]
  ) else $error("auto reload failed");

  a_flag_set: assert property ( // [R4]
    match |=> ctrl_r.interval_flag
  ) else $error("match did not set flag");

  a_flag_sticky: assert property ( // [R5]
    (ctrl_r.interval_flag && !ctl_wr) |=> ctrl_r.interval_flag
  ) else $error("flag cleared by hardware");

  a_enable_zero: assert property ( // [R6]
    !ctrl_r.interval_enable |=> ival_r == 8'h00
  ) else $error("disabled counter not zero");

  a_clock_stop: assert property ( // [R7]
    (!ctrl_r.timeclock_enable && !sfr_wr_in) |=> $stable(time_r[0]) && $stable(time_r[3]) && $stable(ival_r)
  ) else $error("time chain moved with clock disabled");

  a_preset_write: assert property ( // [R8]
    (!ctrl_r.timeclock_enable && sfr_wr_in && sfr_addr_in == `TIC_ADDR_SECONDS) |=> time_r[1] == $past(sfr_wdata_in)
  ) else $error("preset write lost");

  a_irq_gate: assert property ( // [R9]
    irq_out == $past(ctrl_r.interval_flag && irq_enable_in) // [R17]
  ) else $error("interrupt request not gated by enable");

  a_frac_wrap: assert property ( // [R10]
    (tick128 && time_r[0] == `TIC_FRAC_MAX && time_r[1] != `TIC_SECONDS_MAX && !sfr_wr_in)
    |=> time_r[0] == 8'h00 && time_r[1] == 8'($past(time_r[1]) + 8'h01)
  ) else $error("fraction wrap did not carry");

  a_seconds_wrap: assert property ( // [R11]
    (roll[1] && time_r[2] != `TIC_MIN_MAX && !sfr_wr_in)
    |=> time_r[1] == 8'h00 && time_r[2] == 8'($past(time_r[2]) + 8'h01)
  ) else $error("seconds wrap did not carry");

  a_min_wrap: assert property ( // [R12]
    (roll[2] && time_r[3] != `TIC_HOUR_MAX && !sfr_wr_in)
    |=> time_r[2] == 8'h00 && time_r[3] == 8'($past(time_r[3]) + 8'h01)
  ) else $error("minutes wrap did not carry");

  a_hour_wrap: assert property ( // [R13]
    (roll[3] && !sfr_wr_in) |=> time_r[3] == 8'h00
  ) else $error("hours did not wrap to zero");

  a_time_range: assert property ( // [R16]
    ctrl_r.timeclock_enable |-> time_r[0] <= `TIC_FRAC_MAX || $past(!ctrl_r.timeclock_enable)
  ) else $error("fraction register out of range while running");

  a_target_load: assert property ( // [R9]
    wr_hit(sfr_wr_in, sfr_addr_in, `TIC_ADDR_TARGET)
    |=> target_r == $past(sfr_wdata_in)
  ) else $error("interval target write lost");

  a_running_refuse: assert property ( // [R8]
    (ctrl_r.timeclock_enable && wr_hit(sfr_wr_in, sfr_addr_in, `TIC_ADDR_SECONDS) && !carry[1])
    |=> $stable(time_r[1])
  ) else $error("seconds register written while time clock ran");

  a_disable_clear: assert property ( // [R6]
    ival_en_clr |=> ival_r == 8'h00
  ) else $error("interval counter not zeroed by disable write");

  a_clock_clear: assert property ( // [R7]
    clk_en_fall
    |=> time_r[0] == 8'h00 && time_r[1] == 8'h00 && time_r[2] == 8'h00 && time_r[3] == 8'h00 && ival_r == 8'h00
  ) else $error("time registers not cleared when time clock stopped");

  a_frac_step: assert property ( // [R10]
    (tick128 && time_r[0] != `TIC_FRAC_MAX && !sfr_wr_in)
    |=> time_r[0] == 8'($past(time_r[0]) + 8'h01)
  ) else $error("fraction register did not advance");

  a_flag_cause: assert property ( // [R4]
    (!ctrl_r.interval_flag && !match && !ctl_wr) |=> !ctrl_r.interval_flag
  ) else $error("flag set without a match");

  a_enable_hold: assert property ( // [R2]
    (!ctrl_r.interval_enable && !ctl_wr) |=> !ctrl_r.interval_enable
  ) else $error("interval enable set by hardware");

  a_wake_request: assert property ( // [R17]
    (match && irq_enable_in) ##1 irq_enable_in |=> irq_out
  ) else $error("match did not raise the wake request");

  a_reserved_zero: assert property ( // [R14]
    !ctrl_r.res7
  ) else $error("reserved control bit 7 set");

endmodule // tic_top

// File: tb/tic_top_test.sv
// Self-checking bench for the time interval counter
`timescale 1ns/10ps
module tic_top_test;
  localparam int TD = 32;
  logic       clk_in = 1'b0;
  logic       reset_n_in = 1'b0;
  logic [7:0] sfr_addr_in = 8'h00;
  logic       sfr_wr_in = 1'b0;
  logic [7:0] sfr_wdata_in = 8'h00;
  logic [7:0] sfr_rdata_out;
  logic       irq_enable_in = 1'b0;
  logic       irq_out;
  logic [7:0] mx [4] = '{8'h7f, 8'h3b, 8'h3b, 8'h17};
  int         error_cnt = 0;
  int         comparisons = 0;
  int         n;

  always #2 clk_in = ~clk_in;

  tic_top #(.TICK_DIV(TD)) tic_top_i (
    .clk_in        (clk_in),
    .reset_n_in    (reset_n_in),
    .sfr_addr_in   (sfr_addr_in),
    .sfr_wr_in     (sfr_wr_in),
    .sfr_wdata_in  (sfr_wdata_in),
    .sfr_rdata_out (sfr_rdata_out),
    .irq_enable_in (irq_enable_in),
    .irq_out       (irq_out)
  );

  task automatic finish_test();
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic idle(input int k);
    repeat (k) @(posedge clk_in);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_in);
    sfr_addr_in  <= a;
    sfr_wr_in    <= 1'b1;
    sfr_wdata_in <= v;
    @(posedge clk_in);
    sfr_wr_in <= 1'b0;
  endtask

  // Read data is registered, so it is taken one edge after the address
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_in);
    sfr_addr_in <= a;
    @(posedge clk_in);
    #1 chk(sfr_rdata_out, e);
  endtask

  // Watches the flag every cycle, so interval lengths are measured to within a few cycles of read and write latency
  task automatic wait_flag(output int c);
    c = 0;
    @(posedge clk_in);
    sfr_addr_in <= 8'ha1;
    while (c < 40 * TD) begin
      @(posedge clk_in);
      #1 if (sfr_rdata_out[2] === 1'b1) return;
      c++;
    end
    error_cnt++;
    $display("MISMATCH t=%0t interval flag never set", $time);
    finish_test();
  endtask

  // Lower time registers preset to their last value so one tick ripples up
  task automatic tbase(input int k, input int np, input logic [7:0] e);
    wr(8'ha1, 8'h40);
    for (int i = 0; i < np; i++) wr(8'ha2 + 8'(i), mx[i]);
    wr(8'ha6, 8'h01);
    wr(8'ha1, {2'b01, 2'(k), 4'h3});
    idle(2 * TD + 4);
    @(posedge clk_in);
    sfr_addr_in <= 8'ha1;
    @(posedge clk_in);
    #1 chk({5'h00, sfr_rdata_out[2], 2'b00}, e);
  endtask

  initial begin
    repeat (12) @(posedge clk_in);
    reset_n_in <= 1'b1;
    idle(3);
    for (int a = 8'ha0; a <= 8'ha7; a++) rc(8'(a), 8'h00);
    wr(8'ha0, 8'hff);
    rc(8'ha0, 8'h00);
    wr(8'ha6, 8'h5a);
    rc(8'ha6, 8'h5a);
    wr(8'ha1, 8'hc0);
    rc(8'ha1, 8'h40);
    $display("test registers done");

    for (int i = 0; i < 4; i++) wr(8'ha2 + 8'(i), mx[i]);
    for (int i = 0; i < 4; i++) rc(8'ha2 + 8'(i), mx[i]);
    wr(8'ha1, 8'h41);
    idle(TD + 2);
    wr(8'ha3, 8'h05);
    rc(8'ha5, 8'h00);
    rc(8'ha4, 8'h00);
    rc(8'ha3, 8'h00);
    rc(8'ha2, 8'h00);
    idle(3 * TD);
    wr(8'ha1, 8'h40);
    rc(8'ha2, 8'h00);
    $display("test time chain done");

    @(posedge clk_in) irq_enable_in <= 1'b1;
    wr(8'ha6, 8'h03);
    wr(8'ha1, 8'h4b);
    wait_flag(n);
    chk(8'(n >= 3 * TD - 3 && n <= 3 * TD + 3), 8'h01);
    rc(8'ha1, 8'h4d);
    chk({7'h00, irq_out}, 8'h01);
    idle(4 * TD);
    rc(8'ha1, 8'h4d);
    @(posedge clk_in) irq_enable_in <= 1'b0;
    idle(2);
    chk({7'h00, irq_out}, 8'h00);
    $display("test single shot done");

    wr(8'ha1, 8'h40);
    wr(8'ha6, 8'h02);
    wr(8'ha1, 8'h43);
    wait_flag(n);
    wr(8'ha1, 8'h43);
    wait_flag(n);
    chk(8'(n >= 2 * TD - 6 && n <= 2 * TD), 8'h01);
    rc(8'ha1, 8'h47);
    $display("test auto reload done");

    wr(8'ha1, 8'h40);
    wr(8'ha1, 8'h43);
    idle(TD + TD / 2);
    wr(8'ha1, 8'h41);
    wr(8'ha1, 8'h43);
    idle(TD / 2);
    rc(8'ha1, 8'h43);
    $display("test interval disable done");

    for (int k = 0; k < 4; k++) begin
      if (k > 0) tbase(k, k - 1, 8'h00);
      tbase(k, k, 8'h04);
    end
    $display("test timebase done");
    finish_test();
  end
endmodule // tic_top_test
